// ==== hdl/dsrx_pkg.sv ====
// Shared constants and carrier types for the serial receive front end.
// Assumes a single clock domain; no software bus, controls arrive as ports.
package dsrx_pkg;
    // Divisor layout
    localparam int DIV_W       = 12;   // Full divisor width
    localparam int DIV_HI_W    = 4;    // Bits from the high divisor part
    localparam int DIV_LO_W    = 8;    // Bits from the low divisor part
    localparam int DIV_MAX     = 4095; // Largest divisor accepted
    // Control field position within the first control/status byte
    localparam int CTRL_W      = 8;    // Width of the control/status byte
    localparam int DSPEED_BIT  = 1;    // Double-speed select position
    // Oversampling
    localparam int OS_NORMAL   = 16;   // Samples per bit, normal speed
    localparam int OS_DOUBLE   = 8;    // Samples per bit, double speed
    localparam int SMP_W       = 4;    // Width of the sample counter
    localparam int VOTE_A      = 4;    // First voting sample
    localparam int VOTE_B      = 5;    // Second voting sample
    localparam int VOTE_C      = 6;    // Third voting sample, decision point
    localparam int DATA_W      = 8;    // Data bits per character
    localparam int BIT_W       = 4;    // Width of the bit counter
    // Reset values
    localparam logic [SMP_W-1:0] SMP_RST = 4'h0;   // Sample counter reset
    localparam logic [DIV_W-1:0] DIV_RST = 12'h000; // Divider counter reset

    // Received character with its framing status
    typedef struct packed {
        logic [DATA_W-1:0] data;       // Data bits, first received in bit 0
        logic              stop_ok;    // Stop bit voted high
    } rx_char_type;
endpackage

// ==== hdl/dsrx_top.sv ====
// Baud generator and oversampling receive front end with double-speed mode.
// Assumes the divisor parts and control byte are held stable by software
// logic in the same clock domain; the receive pin is asynchronous.
//
// What this block does
// - Double speed: eight samples per bit, not sixteen
// - Double speed samples pin eight times per bit
// - Idle low sample starts qualification as sample 1
// - Samples 4,5,6 mostly high reject start bit
// - Data bits voted majority of samples 4,5,6
// - Shift each bit in once its vote ends
// - Double speed rate is clock over 8(div+1)
// - Divisor is high/low pair, 0 to 4095
// - Select bit is bit 1 of control byte
// - Normal rate is clock over 16(div+1)
// - High part four MSBs, low part eight LSBs
`timescale 1ns/1ps

module dsrx_top
    import dsrx_pkg::*;
#(
    parameter int DATA_BITS = DATA_W   // Data bits per character
)(
    // Clock, reset, enable
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                clk_en_i,
    // Software controls
    input  wire logic [CTRL_W-1:0]   serial_ctrl_status_a_i,
    input  wire logic [DIV_HI_W-1:0] baud_divisor_high_i,
    input  wire logic [DIV_LO_W-1:0] baud_divisor_low_i,
    // Serial line
    input  wire logic                rxd_i,
    // Received character
    output logic                     rx_valid_o,
    output rx_char_type              rx_char_o,
    // Status
    output logic                     sample_tick_o,
    output logic                     rx_busy_o
);

    // Elaboration check: the character layout is fixed at eight bits
    if (DATA_BITS != DATA_W) begin : g_bad_width
        $error("dsrx_top supports only eight data bits");
    end

    ////////////////////////////////////////////////////////////////////////
    // Control decode

    logic             double_speed_select;  // Mode select
    logic [DIV_W-1:0] baud_divisor;         // Combined divisor
    logic [SMP_W-1:0] last_sample;          // Final sample index in a bit

    assign double_speed_select = serial_ctrl_status_a_i[DSPEED_BIT];
    assign baud_divisor = {baud_divisor_high_i, baud_divisor_low_i};
    // Sixteen or eight samples per bit decide both rate and window
    assign last_sample = double_speed_select ? SMP_W'(OS_DOUBLE - 1)
                                             : SMP_W'(OS_NORMAL - 1);

    // Majority of three samples
    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Baud divider: one tick per (divisor+1) clocks, ticks are samples

    logic [DIV_W-1:0] div_cnt_ff;   // Down counter
    logic             tick;         // Oversample strobe

    assign tick = clk_en_i && (div_cnt_ff == DIV_RST);

    // Reload on expiry so a new divisor takes effect at the next tick
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_ff <= DIV_RST;
        end else if (clk_en_i) begin
            if (tick) begin
                div_cnt_ff <= baud_divisor;
            end else begin
                div_cnt_ff <= div_cnt_ff - DIV_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    logic rxd_meta_ff;  // First stage, read only by the second
    logic rxd_sync_ff;  // Safe pin level

    // Pin is asynchronous; two flops before any logic
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxd_meta_ff <= 1'b1;
            rxd_sync_ff <= 1'b1;
        end else if (clk_en_i) begin
            rxd_meta_ff <= rxd_i;
            rxd_sync_ff <= rxd_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive state machine

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_type;

    rx_state_type      state_ff;    // Receiver state
    logic [SMP_W-1:0]  smp_ff;      // Sample index in bit, 0 means sample 1
    logic [BIT_W-1:0]  bit_ff;      // Data bit count
    logic [2:0]        votes_ff;    // Samples 4 and 5 collected
    logic [DATA_W-1:0] shift_ff;    // Receive shift register
    logic              voted;       // Majority of samples 4,5,6
    logic              at_vote;     // Sample 6 is being taken now
    logic              at_end;      // Last sample of a bit

    assign voted   = vote3({rxd_sync_ff, votes_ff[1:0]});
    assign at_vote = tick && (smp_ff == SMP_W'(VOTE_C - 1));
    assign at_end  = tick && (smp_ff == last_sample);

    // Sample index: boundaries every bit period from the first low sample
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            smp_ff <= SMP_RST;
        end else if (clk_en_i && tick) begin
            if (state_ff == ST_IDLE) begin
                // The low sample just seen is sample 1; next tick is sample 2
                smp_ff <= rxd_sync_ff ? SMP_RST : SMP_W'(1);
            end else if (at_end) begin
                smp_ff <= SMP_RST;
            end else begin
                smp_ff <= smp_ff + SMP_W'(1);
            end
        end
    end

    // Capture samples 4 and 5 for the vote
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            votes_ff <= 3'h0;
        end else if (clk_en_i && tick) begin
            if (smp_ff == SMP_W'(VOTE_A - 1)) begin
                votes_ff[0] <= rxd_sync_ff;
            end
            if (smp_ff == SMP_W'(VOTE_B - 1)) begin
                votes_ff[1] <= rxd_sync_ff;
            end
        end
    end

    // Sequence: idle, start qualification, data bits, stop bit
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
            bit_ff   <= 4'h0;
        end else if (clk_en_i && tick) begin
            case (state_ff)
                ST_IDLE: begin
                    // One low sample is taken as the start edge
                    if (!rxd_sync_ff) begin
                        state_ff <= ST_START;
                    end
                end
                ST_START: begin
                    // Mostly high votes mean a spike; go back to hunting
                    if (at_vote && voted) begin
                        state_ff <= ST_IDLE;
                    end else if (at_end) begin
                        state_ff <= ST_DATA;
                        bit_ff   <= 4'h0;
                    end
                end
                ST_DATA: begin
                    if (at_end) begin
                        if (bit_ff == BIT_W'(DATA_BITS - 1)) begin
                            state_ff <= ST_STOP;
                        end else begin
                            bit_ff <= bit_ff + BIT_W'(1);
                        end
                    end
                end
                ST_STOP: begin
                    // Return at the vote so a next start edge is not missed
                    if (at_vote) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Shift each data bit in the moment its vote is known
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_ff <= 8'h00;
        end else if (clk_en_i && at_vote && state_ff == ST_DATA) begin
            shift_ff <= {voted, shift_ff[DATA_W-1:1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output character

    rx_char_type rx_char_ff;    // Held character
    logic        rx_valid_ff;   // Done pulse, one enabled clock long; held while clk_en_i is low

    // Character handed over at the stop bit vote; framing noted
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_char_ff  <= '0;
            rx_valid_ff <= 1'b0;
        end else if (clk_en_i) begin
            rx_valid_ff <= at_vote && (state_ff == ST_STOP);
            if (at_vote && state_ff == ST_STOP) begin
                rx_char_ff.data    <= shift_ff;
                rx_char_ff.stop_ok <= voted;
            end
        end
    end

    assign rx_valid_o    = rx_valid_ff;
    assign rx_char_o     = rx_char_ff;
    assign sample_tick_o = tick;
    assign rx_busy_o     = (state_ff != ST_IDLE);

endmodule

// ==== sim/dsrx_top_asserts.sv ====
// Port checker for the receive front end and its baud generator.
// Assumes mode and divisor change only while reset is held.
`timescale 1ns/1ps
module dsrx_top_asserts
    import dsrx_pkg::*;
#(
    parameter int DATA_BITS = DATA_W   // Data bits per character
)(
    // Clock, reset, controls
    input wire logic                ref_clk_i,
    input wire logic                rst_n_i,
    input wire logic                clk_en_i,
    input wire logic [CTRL_W-1:0]   serial_ctrl_status_a_i,
    input wire logic [DIV_HI_W-1:0] baud_divisor_high_i,
    input wire logic [DIV_LO_W-1:0] baud_divisor_low_i,
    input wire logic                rxd_i,
    // Watched outputs
    input wire logic                rx_valid_o,
    input wire rx_char_type         rx_char_o,
    input wire logic                sample_tick_o,
    input wire logic                rx_busy_o
);
    logic [DIV_W:0] gap_ff;   // Enabled clocks since last tick
    logic           seen_ff;  // First tick passed
    logic [23:0]    len_ff;   // Clocks since busy rose
    int             span;     // Clocks from frame start to done
    assign span = ((DATA_BITS + 1) * (serial_ctrl_status_a_i[DSPEED_BIT] ? OS_DOUBLE : OS_NORMAL)
        + VOTE_C - 1) * ({baud_divisor_high_i, baud_divisor_low_i} + 1);
    ////////////////////////////////////////
    // Tick gap; frozen clocks do not count
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_ff  <= '0;
            seen_ff <= 1'b0;
        end else if (sample_tick_o) begin
            gap_ff  <= '0;
            seen_ff <= 1'b1;
        end else if (clk_en_i) begin
            gap_ff <= gap_ff + 1'b1;
        end
    end
    // Frame length, restarted as busy rises
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) len_ff <= '0;
        else len_ff <= $rose(rx_busy_o) ? 24'h000001 : len_ff + 1'b1;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Idle tick that sees the line low, two sync stages back
    sequence s_start;
        sample_tick_o && !rx_busy_o && !$past(rxd_i, 2);
    endsequence
    a_tick_spacing: assert property (sample_tick_o && seen_ff |->
        gap_ff == {1'b0, baud_divisor_high_i, baud_divisor_low_i}) else $error("tick gap wrong");
    a_tick_frozen: assert property (!clk_en_i |-> !sample_tick_o)
        else $error("tick while disabled");
    a_start_seen: assert property (s_start |=> rx_busy_o)
        else $error("low sample ignored");
    a_idle_holds: assert property (!rx_busy_o && !(sample_tick_o && !$past(rxd_i, 2))
        |=> !rx_busy_o) else $error("left idle without start");
    a_valid_single: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("done pulse too long");
    a_char_moves: assert property ($changed(rx_char_o) |-> rx_valid_o)
        else $error("character changed without done");
    a_done_follows: assert property (rx_valid_o |-> $past(sample_tick_o) && $past(rx_busy_o))
        else $error("done not after a vote tick");
    a_frame_span: assert property (rx_valid_o |-> len_ff == span)
        else $error("character length wrong");
endmodule
bind dsrx_top dsrx_top_asserts #(.DATA_BITS(DATA_BITS)) chk (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .serial_ctrl_status_a_i(serial_ctrl_status_a_i),
    .baud_divisor_high_i(baud_divisor_high_i), .baud_divisor_low_i(baud_divisor_low_i),
    .rxd_i(rxd_i), .rx_valid_o(rx_valid_o), .rx_char_o(rx_char_o),
    .sample_tick_o(sample_tick_o), .rx_busy_o(rx_busy_o));

// ==== sim/dsrx_line_model.sv ====
// Remote serial transmitter on the receive line.
// Assumes go_i pulses only while busy_o is low.
`timescale 1ns/1ps
module dsrx_line_model (
    // Control from the bench
    input  wire logic        ref_clk_i,
    input  wire logic        go_i,
    input  wire logic [9:0]  frame_i,     // Sent from bit 0 up
    input  wire logic [3:0]  nbits_i,     // Bits of frame_i to send
    input  wire logic [23:0] bit_clks_i,  // Clocks per bit
    // Serial side
    output logic             line_o,
    output logic             busy_o
);
    initial begin
        line_o = 1'b1;
        busy_o = 1'b0;
    end
    // Exact bit length, so no rate error; line idles high
    always @(posedge ref_clk_i) begin
        if (go_i) begin
            busy_o <= 1'b1;
            for (int b = 0; b < nbits_i; b++) begin
                line_o <= frame_i[b];
                repeat (bit_clks_i) @(posedge ref_clk_i);
            end
            line_o <= 1'b1;
            busy_o <= 1'b0;
        end
    end
endmodule

// ==== sim/tb_uart_double_speed_rx_baud.sv ====
// Self-checking bench for the double-speed receive front end.
// Assumes the line model as far side and the bound checker.
`timescale 1ns/1ps
module tb_uart_double_speed_rx_baud;
    import dsrx_pkg::*;
    logic              ref_clk = 1'b0;    // 8 ns clock
    logic              rst_n = 1'b0;      // Reset, active low
    logic              clk_en = 1'b1;     // Clock enable
    logic [CTRL_W-1:0] ctrl = 8'h00;      // Control byte
    logic [DIV_W-1:0]  div = 12'h000;     // Whole divisor
    logic              rxd, rx_valid, tick, busy, m_busy;
    logic              go = 1'b0;         // Model start
    rx_char_type       rx_char;           // Received character
    logic [9:0]        frame = 10'h3FF;   // Model bits
    logic [3:0]        nbits = 4'hA;      // Model bit count
    logic [23:0]       bit_clks = 24'h000008;
    int                fails = 0;
    int                comparisons = 0;
    always #4 ref_clk = ~ref_clk;
    dsrx_top dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .clk_en_i(clk_en),
        .serial_ctrl_status_a_i(ctrl), .baud_divisor_high_i(div[11:8]),
        .baud_divisor_low_i(div[7:0]), .rxd_i(rxd), .rx_valid_o(rx_valid), .rx_char_o(rx_char),
        .sample_tick_o(tick), .rx_busy_o(busy));
    dsrx_line_model far (.ref_clk_i(ref_clk), .go_i(go), .frame_i(frame), .nbits_i(nbits),
        .bit_clks_i(bit_clks), .line_o(rxd), .busy_o(m_busy));
    ////////////////////////////////////////
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Bounded wait: 0 tick, 1 done, 2 model idle
    task automatic wait_on(input int sel, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #2 n++;
        end while (!(sel == 0 ? tick === 1'b1 : sel == 1 ? rx_valid === 1'b1 : m_busy === 1'b0)
            && n < 40000);
    endtask
    // Reset into a mode and divisor, time the ticks, then freeze a while
    task automatic setup(input logic ds, input logic [DIV_W-1:0] d);
        int n;
        @(posedge ref_clk);
        #1 rst_n = 1'b0;
        ctrl = {6'h00, ds, 1'b0};
        div = d;
        repeat (5) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        wait_on(0, n);
        wait_on(0, n);
        check(9'(n), 9'(d) + 9'h001);
        @(posedge ref_clk);
        #1 clk_en = 1'b0;
        repeat (12) @(posedge ref_clk);
        #1 clk_en = 1'b1;
        $display("setup mode %0d divisor %0d done", ds, d);
    endtask
    task automatic send(input logic [3:0] nb, input int spb, input logic [9:0] f);
        @(posedge ref_clk);
        #1 frame = f;
        nbits = nb;
        bit_clks = 24'(spb * (div + 1));
        go = 1'b1;
        @(posedge ref_clk);
        #1 go = 1'b0;
    endtask
    task automatic rx_byte(input int spb, input logic [7:0] b, input logic stop);
        int n;
        send(4'hA, spb, {stop, b, 1'b0});
        wait_on(1, n);
        check(9'(n < 40000), 9'h001);
        check(rx_char, {b, stop});
        wait_on(2, n);
        $display("byte %h done", b);
    endtask
    // Low spike of smp samples must be dropped
    task automatic spike(input int smp);
        int n;
        send(4'h1, smp, 10'h3FE);
        wait_on(2, n);
        n = 0;
        repeat (16 * (div + 1)) begin
            @(posedge ref_clk);
            #2 n += (rx_valid !== 1'b0);
        end
        check(9'(n), 9'h000);
        check({8'h00, busy}, 9'h000);
        $display("spike %0d done", smp);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        setup(1'b1, 12'h000);
        rx_byte(OS_DOUBLE, 8'hA5, 1'b1);
        setup(1'b1, 12'h102);
        rx_byte(OS_DOUBLE, 8'h3C, 1'b0);
        setup(1'b0, 12'h001);
        rx_byte(OS_NORMAL, 8'h5A, 1'b1);
        setup(1'b1, 12'h003);
        spike(2);
        spike(4);
        rx_byte(OS_DOUBLE, 8'h81, 1'b1);
        rx_byte(OS_DOUBLE, 8'h7E, 1'b1);
        wrap_up;
    end
    // Watchdog, nearly three times the expected run
    initial begin
        #(60000 * 8);
        fails++;
        wrap_up;
    end
endmodule
